// File: hdl/psc_defines.svh
// timing counts, encodings and limits for the pulse setup and optical session
// assumes a 50 MHz core clock
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
// ============================================================
// clock and times
`define PSC_CLK_HZ 50000000
`define PSC_LONG_PRESS_S 4
`define PSC_SESSION_S 4
`define PSC_IDLE_OFF_S 120
`define PSC_LONG_PRESS_CYC (`PSC_CLK_HZ * `PSC_LONG_PRESS_S)
`define PSC_SESSION_CYC (`PSC_CLK_HZ * `PSC_SESSION_S)
`define PSC_IDLE_OFF_CYC (64'(`PSC_CLK_HZ) * 64'(`PSC_IDLE_OFF_S))
`define PSC_DAY_S 86400
`define PSC_DAY_CYC (64'(`PSC_CLK_HZ) * 64'(`PSC_DAY_S))
// ============================================================
// pulse value codes, 0 is 1 l/pulse (factory default)
`define PSC_PV_DEFAULT 3'h0
`define PSC_PV_LAST 3'h7
// ============================================================
// read-out budget
`define PSC_BUDGET_DAILY 8'h04
`define PSC_BUDGET_MAX 8'h1e
`endif

// File: hdl/psc_pkg.sv
// types shared by the pulse setup and optical session block
package psc_pkg;
  // pulse value codes: 1,2.5,10,25,100,250,1000,2500 l/pulse
  typedef logic [2:0] psc_pulse_t;
  typedef logic [1:0] psc_decimals_t;
  typedef enum logic [2:0] {
    PSC_SES_IDLE = 3'b001,
    PSC_SES_OPEN = 3'b010,
    PSC_SES_SHUT = 3'b100
  } psc_ses_t;
endpackage

// File: hdl/psc_sync_if.sv
// bundle of synchronised pin levels between the top and its input stage
`timescale 1ns/100ps
interface psc_sync_if;
  logic button;
  logic mains;
  logic flow_pulse;
  modport src (output button, mains, flow_pulse);
  modport dst (input button, mains, flow_pulse);
endinterface

// File: hdl/psc_pin_sync.sv
// three-flop synchronisers for the asynchronous pins
// assumes pins are stable levels far slower than the core clock
`timescale 1ns/100ps
module psc_pin_sync #(
  parameter int N = 3
) (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic [N-1:0] pin_i, // raw pins
  output logic [N-1:0] lvl_o // filtered levels
);
  // ============================================================
  // per-pin chain: a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic s1, s2, s3;
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          lvl_o[g] <= 1'b0;
        end else begin
          s1 <= pin_i[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            lvl_o[g] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule

// File: hdl/psc_top.sv
// pulse value setup, optical session control and supply indication
// assumes a debounced button, an external uart flagging frames, 50 MHz clock
`timescale 1ns/100ps
`include "psc_defines.svh"
module psc_top #(
  parameter int LONG_CYC = `PSC_LONG_PRESS_CYC,
  parameter int SES_CYC = `PSC_SESSION_CYC,
  parameter longint IDLE_CYC = `PSC_IDLE_OFF_CYC,
  parameter longint DAY_CYC = `PSC_DAY_CYC,
  parameter bit PRESET_VARIANT = 1'b0
) (
  input wire logic core_clk_i, // 50 MHz clock
  input wire logic rstn_i, // async reset, active low
  input wire logic button_i, // push-button pin, high pressed
  input wire logic mains_i, // external supply sense pin
  input wire logic flow_pulse_i, // flow meter pulse pin
  input wire logic wake_hdr_i, // uart saw the wake header, pulse
  input wire logic valid_frame_i, // uart saw a valid exchange, pulse
  output psc_pkg::psc_pulse_t pulse_val_o, // shown or committed value
  output logic pulse_locked_o, // value committed
  output psc_pkg::psc_decimals_t decimals_o, // display decimals
  output logic display_on_o, // display enabled
  output logic optical_open_o, // optical session open
  output logic mains_icon_o, // mains plug pictogram
  output logic on_battery_o, // running from backup battery
  output logic [7:0] budget_o // read-outs left
);
  import psc_pkg::*;
  // ============================================================
  // reset release
  logic rst_a, rst_n;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_a <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_n <= rst_a;
    end
  end
  // ============================================================
  // pin synchronisers
  psc_sync_if sif ();
  logic [2:0] lvl;
  psc_pin_sync #(.N(3)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pin_i({flow_pulse_i, mains_i, button_i}),
    .lvl_o(lvl)
  );
  assign sif.button = lvl[0];
  assign sif.mains = lvl[1];
  assign sif.flow_pulse = lvl[2];
  // ============================================================
  // button press timing
  logic btn_q, flow_q;
  logic [31:0] hold_cnt;
  logic long_fired;
  logic brief_ev, long_ev, press_ev, flow_ev;
  assign press_ev = sif.button & ~btn_q;
  // brief on release before threshold
  assign brief_ev = ~sif.button & btn_q & ~long_fired;
  // long fires once on the threshold cycle
  assign long_ev = sif.button & ~long_fired &
                   (hold_cnt == 32'(LONG_CYC - 1));
  assign flow_ev = sif.flow_pulse & ~flow_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      btn_q <= 1'b0;
      flow_q <= 1'b0;
      hold_cnt <= 32'h0;
      long_fired <= 1'b0;
    end else begin
      btn_q <= sif.button;
      flow_q <= sif.flow_pulse;
      if (!sif.button) begin
        hold_cnt <= 32'h0;
        long_fired <= 1'b0;
      end else begin
        if (hold_cnt != 32'(LONG_CYC - 1)) begin
          hold_cnt <= hold_cnt + 32'h1;
        end
        if (long_ev) begin
          long_fired <= 1'b1;
        end
      end
    end
  end
  // ============================================================
  // pulse value selection and commit; the flops model retained storage
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pulse_val_o <= `PSC_PV_DEFAULT;
      pulse_locked_o <= 1'b0;
    end else if (!pulse_locked_o) begin
      if (long_ev) begin
        pulse_locked_o <= 1'b1;
      end else if (PRESET_VARIANT && flow_ev) begin
        pulse_locked_o <= 1'b1;
      end else if (brief_ev) begin
        pulse_val_o <= pulse_val_o + 3'h1;
      end
    end
  end
  // decimals from pulse value pairs
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      decimals_o <= 2'h3;
    end else begin
      decimals_o <= 2'h3 - 2'(pulse_val_o[2:1]);
    end
  end
  // ============================================================
  // optical session state machine
  psc_ses_t ses, next_ses;
  logic [31:0] ses_cnt;
  logic ses_expire;
  logic grant;
  assign grant = budget_o != 8'h00;
  assign ses_expire = (ses == PSC_SES_OPEN) &&
                      (ses_cnt == 32'(SES_CYC - 1)) && !valid_frame_i;
  always_comb begin
    next_ses = ses;
    case (ses)
      PSC_SES_IDLE: begin
        if (wake_hdr_i && grant) begin
          next_ses = PSC_SES_OPEN;
        end
      end
      PSC_SES_OPEN: begin
        if (ses_expire) begin
          next_ses = PSC_SES_SHUT;
        end
      end
      PSC_SES_SHUT: next_ses = PSC_SES_IDLE;
      default: next_ses = PSC_SES_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ses <= PSC_SES_IDLE;
      ses_cnt <= 32'h0;
    end else begin
      ses <= next_ses;
      if (ses != PSC_SES_OPEN || valid_frame_i) begin
        ses_cnt <= 32'h0;
      end else begin
        ses_cnt <= ses_cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      optical_open_o <= 1'b0;
    end else begin
      optical_open_o <= (next_ses == PSC_SES_OPEN);
    end
  end
  // ============================================================
  // read-out budget: refilled daily, unused allowance accumulates up to PSC_BUDGET_MAX (8'h1e)
  logic [63:0] day_cnt;
  logic day_ev, read_ev;
  assign day_ev = day_cnt == 64'(DAY_CYC - 1);
  assign read_ev = (ses == PSC_SES_IDLE) && wake_hdr_i && grant;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      day_cnt <= 64'h0;
      budget_o <= `PSC_BUDGET_DAILY;
    end else begin
      day_cnt <= day_ev ? 64'h0 : day_cnt + 64'h1;
      if (day_ev) begin
        if (budget_o > `PSC_BUDGET_MAX - `PSC_BUDGET_DAILY) begin
          budget_o <= `PSC_BUDGET_MAX - 8'(read_ev);
        end else begin
          budget_o <= budget_o + `PSC_BUDGET_DAILY - 8'(read_ev);
        end
      end else if (read_ev) begin
        budget_o <= budget_o - 8'h01;
      end
    end
  end
  // ============================================================
  // display on/off
  logic [63:0] idle_cnt;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 64'h0;
      display_on_o <= 1'b0;
    end else begin
      if (press_ev) begin
        idle_cnt <= 64'h0;
        display_on_o <= 1'b1;
      end else if (ses_expire) begin
        display_on_o <= 1'b0;
      end else if (display_on_o && !sif.button) begin
        if (idle_cnt == 64'(IDLE_CYC - 1)) begin
          display_on_o <= 1'b0;
        end else begin
          idle_cnt <= idle_cnt + 64'h1;
        end
      end
    end
  end
  // ============================================================
  // supply indication
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mains_icon_o <= 1'b0;
      on_battery_o <= 1'b1;
    end else begin
      mains_icon_o <= sif.mains;
      on_battery_o <= ~sif.mains;
    end
  end
  // ============================================================
  // checks
  // once committed the value and the lock never move
  AST_LOCK_HOLD: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    pulse_locked_o |=> pulse_locked_o && $stable(pulse_val_o))
    else $error("pulse value changed after commit");
  // a brief press while unset steps the code by one
  AST_BRIEF_STEP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (brief_ev && !pulse_locked_o && !(PRESET_VARIANT && flow_ev))
    |=> pulse_val_o == $past(pulse_val_o) + 3'h1)
    else $error("brief press did not step value");
  // the threshold crossing commits on the next edge
  AST_LONG_LOCK: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    long_ev |=> pulse_locked_o)
    else $error("long press did not commit");
  // the long action is a single-cycle event
  AST_LONG_ONCE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    long_ev |=> !long_ev)
    else $error("long press fired twice");
  // releasing after the threshold is not a brief press
  AST_LONG_NO_STEP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (long_fired && !sif.button) |=> $stable(pulse_val_o))
    else $error("long press also stepped the value");
  // decimals follow the code pairs one cycle later
  AST_DECIMALS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ##1 decimals_o == 2'h3 - 2'($past(pulse_val_o[2:1])))
    else $error("decimals mismatch");
  // a flow pulse does not commit outside the preset variant
  AST_FLOW_KEEP: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (!PRESET_VARIANT && flow_ev && !long_ev && !pulse_locked_o)
    |=> !pulse_locked_o)
    else $error("flow pulse committed the value");
  // no header, no session
  AST_WAKE_OPEN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (ses == PSC_SES_IDLE && !wake_hdr_i) |=> !optical_open_o)
    else $error("port opened without header");
  // a granted header opens the port on the next edge
  AST_WAKE_GRANT: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    read_ev |=> optical_open_o)
    else $error("granted header did not open the port");
  // the port stays open while the window is still running
  AST_OPEN_WIN: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (ses == PSC_SES_OPEN && ses_cnt < 32'(SES_CYC - 1)) |=> optical_open_o)
    else $error("session closed inside its window");
  // a valid exchange restarts the window
  AST_FRAME_RESTART: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (ses == PSC_SES_OPEN && valid_frame_i) |=> ses_cnt == 32'h0 &&
    ses == PSC_SES_OPEN)
    else $error("valid frame did not restart window");
  // expiry closes the port and blanks the display
  AST_EXPIRE_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (ses_expire && !press_ev) |=> !display_on_o && !optical_open_o)
    else $error("expiry left session or display on");
  // the shut state lasts one cycle
  AST_SHUT_IDLE: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ses == PSC_SES_SHUT |=> ses == PSC_SES_IDLE)
    else $error("session stuck after close");
  // an empty budget opens no new session
  AST_BUDGET: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (budget_o == 8'h00 && !day_ev) |=> !optical_open_o ||
    $past(optical_open_o))
    else $error("session granted with empty budget");
  // each granted read-out costs one unit
  AST_READ_COST: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (read_ev && !day_ev) |=> budget_o == $past(budget_o) - 8'h01)
    else $error("read-out not charged");
  // a quiet day never shrinks the allowance
  AST_DAY_GROW: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (day_ev && !read_ev) |=> budget_o >= $past(budget_o))
    else $error("daily refill lost allowance");
  // a press lights the display
  AST_PRESS_ON: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    press_ev |=> display_on_o)
    else $error("press did not light the display");
  // the idle limit blanks the display
  AST_IDLE_OFF: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (display_on_o && !sif.button && !press_ev &&
    idle_cnt == 64'(IDLE_CYC - 1)) |=> !display_on_o)
    else $error("display stayed on past the idle limit");
  // the supply flags track the mains pin
  AST_MAINS: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    ##1 mains_icon_o == $past(sif.mains) &&
    on_battery_o == !mains_icon_o)
    else $error("supply indication wrong");
endmodule

// File: sim/psc_opto_head.sv
// optocoupler head model: sends wake headers and valid exchanges
// assumes the uart beside the block turns each into a one-cycle pulse
`timescale 1ns/100ps
module psc_opto_head (
  input wire logic core_clk_i, // core clock
  output logic wake_hdr_o, // wake header seen
  output logic valid_frame_o // valid exchange seen
);
  // ==========================================================
  // link idle: no traffic
  initial begin
    wake_hdr_o = 1'b0;
    valid_frame_o = 1'b0;
  end
  // one decoded wake header, a single pulse
  task automatic wake();
    @(posedge core_clk_i);
    wake_hdr_o <= 1'b1;
    @(posedge core_clk_i);
    wake_hdr_o <= 1'b0;
  endtask
  // one valid exchange after gap quiet cycles, prompt or slow
  task automatic frame(input int gap);
    repeat (gap) @(posedge core_clk_i);
    valid_frame_o <= 1'b1;
    @(posedge core_clk_i);
    valid_frame_o <= 1'b0;
  endtask
endmodule

// File: sim/psc_top_bench.sv
// self-checking bench for the pulse setup and optical session block
// assumes shortened counts: long 20, window 30, idle 400, day 2000 cycles
`timescale 1ns/100ps
module psc_top_bench;
  import psc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic button = 1'b0;
  logic mains = 1'b0;
  logic flow = 1'b0;
  logic wake_hdr;
  logic valid_frame;
  psc_pulse_t pulse_val;
  psc_decimals_t decimals;
  logic pulse_locked, display_on, optical_open, mains_icon, on_battery;
  logic [7:0] budget;
  int n_mismatch = 0;
  int check_count = 0;
  // ==========================================================
  // block and far side
  psc_top #(.LONG_CYC(20), .SES_CYC(30), .IDLE_CYC(400),
    .DAY_CYC(2000)) i_dut (
    .core_clk_i(core_clk), .rstn_i(rstn), .button_i(button),
    .mains_i(mains), .flow_pulse_i(flow), .wake_hdr_i(wake_hdr),
    .valid_frame_i(valid_frame), .pulse_val_o(pulse_val),
    .pulse_locked_o(pulse_locked), .decimals_o(decimals),
    .display_on_o(display_on), .optical_open_o(optical_open),
    .mains_icon_o(mains_icon), .on_battery_o(on_battery),
    .budget_o(budget));
  psc_opto_head i_head (.core_clk_i(core_clk), .wake_hdr_o(wake_hdr),
    .valid_frame_o(valid_frame));
  // 50 MHz clock
  initial forever #10 core_clk = ~core_clk;
  // ==========================================================
  // helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // wait n edges, then settle past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait for the session flag; a miss ends the run
  task automatic wait_open(input logic lvl, input int lim);
    #1;
    for (int i = 0; i < lim && optical_open !== lvl; i++) tick(1);
    chk_bit(optical_open, lvl);
    if (optical_open !== lvl) give_verdict();
  endtask
  task automatic press(input int n);
    @(posedge core_clk);
    button <= 1'b1;
    tick(n);
    @(posedge core_clk);
    button <= 1'b0;
    tick(8);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk_val(8'(pulse_val), 8'h00);
    chk_bit(pulse_locked, 1'b0);
    chk_val(8'(decimals), 8'h03);
    chk_bit(optical_open, 1'b0);
    chk_val(budget, 8'h04);
    chk_bit(on_battery, 1'b1);
  endtask
  // brief presses walk all codes and wrap, decimals follow
  task automatic t_step();
    for (int i = 1; i <= 10; i++) begin
      press(5);
      chk_val(8'(pulse_val), 8'(i % 8));
      chk_val(8'(decimals), 8'(3 - (i % 8) / 2));
    end
    @(posedge core_clk);
    flow <= 1'b1;
    tick(6);
    @(posedge core_clk);
    flow <= 1'b0;
    tick(6);
    chk_bit(pulse_locked, 1'b0);
    chk_bit(pulse_locked, 1'b0);
    chk_bit(display_on, 1'b1);
  endtask
  // long hold commits code 2, later presses refused
  task automatic t_commit();
    @(posedge core_clk);
    button <= 1'b1;
    tick(30);
    chk_bit(pulse_locked, 1'b1);
    chk_val(8'(pulse_val), 8'h02);
    @(posedge core_clk);
    button <= 1'b0;
    tick(8);
    chk_val(8'(pulse_val), 8'h02);
    press(5);
    chk_val(8'(pulse_val), 8'h02);
    chk_val(8'(decimals), 8'h02);
  endtask
  task automatic t_idle();
    tick(380);
    chk_bit(display_on, 1'b1);
    tick(40);
    chk_bit(display_on, 0);
  endtask
  // frames keep the session open past one window, then it closes
  task automatic t_session();
    press(5);
    i_head.wake();
    wait_open(1'b1, 6);
    chk_val(budget, 8'h03);
    repeat (3) begin
      i_head.frame(20);
      #1;
      chk_bit(optical_open, 1'b1);
    end
    tick(25);
    chk_bit(optical_open, 1'b1);
    wait_open(1'b0, 10);
    chk_bit(display_on, 1'b0);
  endtask
  // window without frames still open after 26 cycles and shut within 8 more, then the budget runs dry and a wake is ignored
  task automatic t_budget();
    for (int k = 2; k <= 4; k++) begin
      i_head.wake();
      wait_open(1'b1, 6);
      chk_val(budget, 8'(4 - k));
      tick(26);
      chk_bit(optical_open, 1'b1);
      wait_open(1'b0, 8);
      tick(3);
    end
    i_head.wake();
    tick(6);
    chk_bit(optical_open, 1'b0);
    chk_val(budget, 8'h00);
  endtask
  task automatic t_mains();
    @(posedge core_clk);
    mains <= 1'b1;
    tick(8);
    chk_bit(mains_icon, 1'b1);
    chk_bit(on_battery, 1'b0);
    @(posedge core_clk);
    mains <= 1'b0;
    tick(8);
    chk_bit(mains_icon, 1'b0);
    chk_bit(on_battery, 1'b1);
  endtask
  // quiet days refill the budget and let it grow
  task automatic t_refill();
    for (int i = 0; i < 2100 && budget == 8'h00; i++) tick(1);
    chk_val(budget, 8'h04);
    if (budget == 8'h00) give_verdict();
    tick(2010);
    chk_val(budget, 8'h08);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    tick(4);
    t_reset();
    t_step();
    t_commit();
    t_idle();
    t_session();
    t_budget();
    t_mains();
    t_refill();
    give_verdict();
  end
endmodule
